/* File: selftest_pkg.sv */
package selftest_pkg;

  // Sample and refresh timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned SAMPLE_HZ       = 500_000;
  localparam int unsigned SAMPLE_DIV      = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned REFRESH_NS      = 2_000;
  localparam int unsigned CLK_NS          = 20;
  localparam int unsigned REFRESH_CYC     = REFRESH_NS / CLK_NS;
  localparam int unsigned DIV_W           = 7;
  localparam logic [DIV_W-1:0] DIV_LAST   = DIV_W'(SAMPLE_DIV - 1);
  localparam logic [DIV_W-1:0] REF_LAST   = DIV_W'(REFRESH_CYC - 1);

  // Self-test intervals, counted in sample ticks
  localparam int unsigned ENABLE_TICKS    = 64;
  localparam int unsigned WIN1_TICKS      = 32;
  localparam int unsigned WIN2_TICKS      = 32;
  localparam int unsigned TICK_W          = 16;

  localparam int unsigned FAULT_W         = 5;

  typedef enum logic [2:0] {
    ST_ARM   = 3'b000,
    ST_WAIT  = 3'b001,
    ST_WIN1  = 3'b010,
    ST_WIN2  = 3'b011,
    ST_DONE  = 3'b100
  } st_state_t;

endpackage

/* File: sync2.sv */
`timescale 1ns/1ns
module sync2 (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* File: magnetic_switch_selftest_control.sv */
`timescale 1ns/1ns
// Notes on behaviour
// RL1 - Output follows field comparison with hysteresis between thresholds.
// RL2 - Comparison sampled at 500 kHz; output state updated every 2 us.
// RL3 - Overtemperature or safety fault overrides output to high-impedance.
// RL4 - Any internal monitor fault shows as high-impedance output.
// RL5 - Host powers up and holds output low through the enable interval.
// RL6 - Test starts only after low through enable interval, then rise.
// RL7 - Self-test runs at most once per power cycle.
// RL8 - First window emulates a field and drives output on.
// RL9 - Second window emulates opposite field and releases output.
// RL10 - After second window, normal switching resumes regardless of result.
// RL11 - Early rise before enable interval expires skips the test.
// RL12 - Enable and window durations are parameters in sample ticks.
module magnetic_switch_selftest_control
  import selftest_pkg::*;
#(
  parameter int unsigned ENABLE_LEN = ENABLE_TICKS, // RL12
  parameter int unsigned WIN1_LEN   = WIN1_TICKS,
  parameter int unsigned WIN2_LEN   = WIN2_TICKS
) (
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic               field_above_on,
  input  wire logic               field_below_off,
  input  wire logic               overtemp_fault,
  input  wire logic [FAULT_W-1:0] monitor_fault,
  input  wire logic               out_pin_i,
  output logic                    out_pin_o,
  output logic                    out_pin_oe_n,
  output logic                    selftest_active,
  output logic                    selftest_used
);

  logic               on_sync;
  logic               off_sync;
  logic               ot_sync;
  logic               pin_sync;
  logic [FAULT_W-1:0] mon_sync;
  logic [DIV_W-1:0]   div_r;
  logic [DIV_W-1:0]   ref_r;
  logic               sw_on_r;
  logic               sw_on_nxt;
  logic               drive_r;
  logic               drive_nxt;
  logic [TICK_W-1:0]  cnt_r;
  logic [TICK_W-1:0]  cnt_nxt;
  logic [TICK_W-1:0]  cnt_inc;
  st_state_t          st_r;
  st_state_t          st_nxt;
  logic               used_r;

  sync2 u_on (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (field_above_on),
    .q       (on_sync)
  );
  sync2 u_off (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (field_below_off),
    .q       (off_sync)
  );
  sync2 u_ot (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (overtemp_fault),
    .q       (ot_sync)
  );
  // Reset value low matches a host that holds the line low at power-on
  sync2 u_pin (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (out_pin_i),
    .q       (pin_sync)
  );

  genvar g;
  generate
    for (g = 0; g < FAULT_W; g++) begin : g_mon
      sync2 u_mon (
        .clk_sys (clk_sys),
        .srst    (srst),
        .d       (monitor_fault[g]),
        .q       (mon_sync[g])
      );
    end
  endgenerate

  // Last count of an interval; a length of zero is not supported
  function automatic logic cnt_last(input logic [TICK_W-1:0] cnt,
                                    input int unsigned       len);
    return cnt == TICK_W'(len - 1);
  endfunction

  wire sample_tick  = (div_r == DIV_LAST);  // RL2
  wire refresh_tick = (ref_r == REF_LAST);  // RL2
  wire any_fault    = ot_sync | (|mon_sync);  // RL3 RL4
  wire in_win1      = (st_r == ST_WIN1);  // RL8
  wire in_win2      = (st_r == ST_WIN2);  // RL9

  assign cnt_inc = cnt_r + 1'b1;

  // Hysteresis: on above upper point, off below lower, else hold
  always_comb begin
    sw_on_nxt = sw_on_r;
    if (sample_tick) begin
      if (on_sync)
        sw_on_nxt = 1'b1;  // RL1
      else if (off_sync)
        sw_on_nxt = 1'b0;  // RL1
    end
  end

  // Sequencer; counts run in sample ticks so the host sees stable windows
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      ST_ARM: begin
        if (pin_sync)
          st_nxt = ST_DONE;  // RL11
        else if (sample_tick) begin
          if (cnt_last(cnt_r, ENABLE_LEN)) begin
            st_nxt  = ST_WAIT;  // RL6
            cnt_nxt = '0;
          end else
            cnt_nxt = cnt_inc;
        end
      end
      // No time limit here: the host may raise the line at any later time
      ST_WAIT: begin
        if (pin_sync) begin
          st_nxt  = ST_WIN1;  // RL6
          cnt_nxt = '0;
        end
      end
      ST_WIN1: begin
        if (sample_tick) begin
          if (cnt_last(cnt_r, WIN1_LEN)) begin
            st_nxt  = ST_WIN2;  // RL9
            cnt_nxt = '0;
          end else
            cnt_nxt = cnt_inc;
        end
      end
      ST_WIN2: begin
        if (sample_tick) begin
          if (cnt_last(cnt_r, WIN2_LEN)) begin
            st_nxt  = ST_DONE;  // RL10
            cnt_nxt = '0;
          end else
            cnt_nxt = cnt_inc;
        end
      end
      ST_DONE: st_nxt = ST_DONE;  // RL7
      default: st_nxt = ST_DONE;
    endcase
  end

  // Faults win over test and normal switching
  // Refresh takes the state held from the previous sample: one period lag
  always_comb begin
    drive_nxt = drive_r;
    if (any_fault)
      drive_nxt = 1'b0;  // RL3 RL4
    else if (in_win1)
      drive_nxt = 1'b1;  // RL8
    else if (in_win2)
      drive_nxt = 1'b0;  // RL9
    else if (refresh_tick)
      drive_nxt = sw_on_r;  // RL1 RL10
  end

  always_ff @(posedge clk_sys) begin
    if (srst)
      div_r <= '0;
    else
      div_r <= sample_tick ? '0 : div_r + 1'b1;  // RL2
  end

  // Kept apart from the sample divider so the refresh period can differ
  always_ff @(posedge clk_sys) begin
    if (srst)
      ref_r <= '0;
    else
      ref_r <= refresh_tick ? '0 : ref_r + 1'b1;  // RL2
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sw_on_r <= 1'b0;
      drive_r <= 1'b0;
    end else begin
      sw_on_r <= sw_on_nxt;
      drive_r <= drive_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r  <= ST_ARM;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Only a power-on clears this, so a test runs once per power cycle
  always_ff @(posedge clk_sys) begin
    if (srst)
      used_r <= 1'b0;
    else if (in_win1)
      used_r <= 1'b1;  // RL7
  end

  // Open drain: only ever pulls low
  assign out_pin_o       = 1'b0;
  assign out_pin_oe_n    = ~drive_r;
  assign selftest_active = in_win1 || in_win2;
  assign selftest_used   = used_r;

endmodule

/* File: host_model.sv */
`timescale 1ns/1ns
module host_model (
  input  wire logic pull_low,
  input  wire logic out_pin_o,
  input  wire logic out_pin_oe_n,
  output logic      line
);
  // Pull-up wins only when neither party sinks the line
  assign line = pull_low ? 1'b0 : (out_pin_oe_n ? 1'b1 : out_pin_o);
endmodule

/* File: mss_checker.sv */
`timescale 1ns/1ns
module mss_checker import selftest_pkg::*; (
  input wire logic               clk_sys,
  input wire logic               srst,
  input wire logic               field_above_on,
  input wire logic               overtemp_fault,
  input wire logic [FAULT_W-1:0] monitor_fault,
  input wire logic               out_pin_i,
  input wire logic               out_pin_oe_n,
  input wire logic               selftest_active,
  input wire logic               selftest_used
);
  wire ok = !overtemp_fault && !(|monitor_fault);
  wire on_ok = ok && field_above_on;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_start; $rose(selftest_active); endsequence
  sequence s_on; (on_ok && selftest_used && !selftest_active)[*8]; endsequence
  property p_temp; overtemp_fault[*4] |-> out_pin_oe_n; endproperty
  a_temp: assert property (p_temp) else $error("hot drive");
  property p_mon; (|monitor_fault)[*4] |-> out_pin_oe_n; endproperty
  a_mon: assert property (p_mon) else $error("fault drive");
  property p_go; s_start |-> $past(out_pin_i, 2); endproperty
  a_go: assert property (p_go) else $error("bad start");
  property p_once; selftest_used |-> !$rose(selftest_active); endproperty
  a_once: assert property (p_once) else $error("rerun");
  property p_win1; s_start ##0 ok |=> !out_pin_oe_n; endproperty
  a_win1: assert property (p_win1) else $error("win1 off");
  property p_win2; $fell(selftest_active) |-> $past(out_pin_oe_n); endproperty
  a_win2: assert property (p_win2) else $error("win2 on");
  property p_len;
    s_start |-> selftest_active[*8] ##[1:600] !selftest_active;
  endproperty
  a_len: assert property (p_len) else $error("window len");
  property p_on; s_on |-> ##[0:200] (!out_pin_oe_n || !on_ok); endproperty
  a_on: assert property (p_on) else $error("no switch");
endmodule
bind magnetic_switch_selftest_control mss_checker mss_checker_inst (.*);

/* File: magnetic_switch_selftest_control_tb_top.sv */
`timescale 1ns/1ns
module magnetic_switch_selftest_control_tb_top import selftest_pkg::*;;
  logic clk_sys = 0, srst = 1, fa = 0, fb = 0, hot = 0, pull = 1;
  logic [FAULT_W-1:0] mon = '0;
  logic line, o, oe_n, act, used;
  int errors = 0, checks = 0, cyc = 0;
  initial forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end
  magnetic_switch_selftest_control #(.ENABLE_LEN(2), .WIN1_LEN(2),
    .WIN2_LEN(2)) magnetic_switch_selftest_control_inst (
    .clk_sys(clk_sys), .srst(srst), .field_above_on(fa),
    .field_below_off(fb), .overtemp_fault(hot), .monitor_fault(mon),
    .out_pin_i(line), .out_pin_o(o), .out_pin_oe_n(oe_n),
    .selftest_active(act), .selftest_used(used));
  host_model host_model_inst (.pull_low(pull), .out_pin_o(o),
    .out_pin_oe_n(oe_n), .line(line));
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task t_selftest;
    tick(350);
    chk(act, 8'h00);
    chk(o, 8'h00);
    pull = 0;
    tick(4);
    chk(act, 8'h01);
    tick(2);
    chk(oe_n, 8'h00);
    tick(250);
    chk({act, oe_n}, 8'h03);
    tick(200);
    chk({used, act}, 8'h02);
    $display("test selftest done");
  endtask
  task t_switch;
    fa = 1;
    tick(210);
    chk(oe_n, 8'h00);
    fa = 0;
    tick(210);
    chk(oe_n, 8'h00);
    $display("test switch done");
  endtask
  task t_fault;
    hot = 1;
    tick(4);
    chk(oe_n, 8'h01);
    hot = 0;
    tick(210);
    chk(oe_n, 8'h00);
    mon = 5'h04;
    tick(4);
    chk(oe_n, 8'h01);
    mon = '0;
    tick(210);
    chk(oe_n, 8'h00);
    $display("test fault done");
  endtask
  task t_release;
    fb = 1;
    tick(210);
    chk(oe_n, 8'h01);
    fb = 0;
    tick(210);
    chk(oe_n, 8'h01);
    $display("test release done");
  endtask
  task t_once;
    pull = 1;
    tick(350);
    pull = 0;
    tick(10);
    chk({used, act}, 8'h02);
    $display("test once done");
  endtask
  task t_skip;
    srst = 1;
    pull = 1;
    tick(16);
    chk({used, act, oe_n}, 8'h01);
    srst = 0;
    tick(50);
    pull = 0;
    tick(600);
    chk({used, act}, 8'h00);
    $display("test skip done");
  endtask
  task results;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    tick(16);
    srst = 0;
    t_selftest();
    t_switch();
    t_fault();
    t_release();
    t_once();
    t_skip();
    results();
  end
endmodule
